// file: slfc_pkg.sv
package slfc_pkg;
	// Register indices; the byte address on the bus is four times the index
	localparam logic [7:0] ADDR_CTRL_A     = 8'hE4;
	localparam logic [7:0] ADDR_CTRL_B     = 8'hE5;
	localparam logic [7:0] ADDR_FRAME_RATE = 8'hE6;
	localparam logic [7:0] ADDR_CONTRAST   = 8'hE7;
	localparam logic [7:0] ADDR_SEG_BASE   = 8'hEC;
	localparam int         SEG_WORDS       = 20;
	localparam int BIT_DRIVE_ENABLE  = 7;
	localparam int BIT_LOW_POWER     = 6;
	localparam int BIT_FRAME_FLAG    = 4;
	localparam int BIT_IRQ_ENABLE    = 3;
	localparam int BIT_BUF_OFF       = 2;
	localparam int BIT_SUPPLY_OFF    = 1;
	localparam int BIT_BLANK         = 0;
	localparam int BIT_CLOCK_SEL     = 7;
	localparam int BIT_HALF_BIAS     = 6;
	localparam int POS_COMMON_COUNT  = 4;
	localparam logic [7:0] CTRL_A_WMASK  = 8'hCF;
	localparam logic [7:0] CTRL_B_WMASK  = 8'hF7;
	localparam logic [7:0] FRAME_WMASK   = 8'h77;
	localparam logic [7:0] RESET_VALUE   = 8'h00;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	localparam int         FRAME_CYCLES  = 256;
endpackage

// file: slfc_seg_mem.sv
`timescale 1ns/100ps
module slfc_seg_mem #(
	parameter int WORDS = 20,
	parameter int AW    = 5
) (
	input  wire logic          i_clk_sys,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [7:0]    i_wdata,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [7:0]    o_rdata
);
	logic [7:0] mem [WORDS];
	always_ff @(posedge i_clk_sys) begin
		if (i_we)
			mem[i_waddr] <= i_wdata;
		o_rdata <= mem[i_raddr];
	end
endmodule

// file: slfc_frame_timer.sv
`timescale 1ns/100ps
// ----------------------------------------
// Frame strobe generator
// ----------------------------------------
// One pulse per frame while running; the count restarts when disabled.
module slfc_frame_timer #(
	parameter int FRAME_CYCLES = 256
) (
	input  wire logic i_clk_sys,
	input  wire logic i_resetn,
	input  wire logic i_run,
	output logic      o_frame_start
);
	logic [15:0] cnt_q;
	wire         at_end = (cnt_q == 16'(FRAME_CYCLES - 1));
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q         <= 16'h0000;
			o_frame_start <= 1'b0;
		end else begin
			cnt_q         <= (!i_run || at_end) ? 16'h0000 : cnt_q + 16'h0001;
			o_frame_start <= i_run && at_end;
		end
	end
endmodule

// file: slfc_top.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module slfc_top
	import slfc_pkg::*;
#(
	parameter int FRAME_CYCLES_P = slfc_pkg::FRAME_CYCLES
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_resetn,
	input  wire logic [9:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [9:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	input  wire logic        i_global_irq_en,
	input  wire logic        i_irq_vector_taken,
	output logic             o_frame_irq,
	output logic             o_pins_lcd_mode,
	output logic             o_blank_active,
	output logic             o_low_power_wave,
	output logic             o_level_buffer_off,
	output logic             o_internal_supply_off,
	output logic             o_drive_clock_sel,
	output logic             o_half_bias_sel,
	output logic [3:0]       o_common_en,
	output logic [2:0]       o_segment_pin_mask,
	output logic [7:0]       o_contrast,
	output logic [7:0]       o_seg_data,
	output logic [4:0]       o_seg_index
);
	import slfc_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ctrl_a_q, ctrl_b_q, frame_rate_q, contrast_q;
	logic       blank_lat_q, low_power_lat_q, odd_frame_q;
	logic [7:0] contrast_lat_q;
	logic [4:0] scan_q;
	logic [4:0] scan_d1_q;
	logic       aw_held_q, w_held_q;
	logic [9:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic       rd_pend_q;
	logic [9:0] araddr_q;
	logic [7:0] seg_rdata;

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	wire aw_fire = i_awvalid && o_awready;
	wire w_fire  = i_wvalid && o_wready;
	wire do_wr   = aw_held_q && w_held_q && !o_bvalid;
	wire [7:0] wbyte   = wdata_q[7:0];
	wire       wlane   = wstrb_q[0];
	wire [7:0] widx    = awaddr_q[9:2];
	wire       walign  = (awaddr_q[1:0] == 2'h0);
	wire       wr_a    = do_wr && wlane && walign && (widx == ADDR_CTRL_A);
	wire       wr_b    = do_wr && wlane && walign && (widx == ADDR_CTRL_B);
	wire       wr_fr   = do_wr && wlane && walign && (widx == ADDR_FRAME_RATE);
	wire       wr_cc   = do_wr && wlane && walign && (widx == ADDR_CONTRAST);
	wire [7:0] seg_off = widx - ADDR_SEG_BASE;
	// Nine bits: the last segment index sits at the top of the 8-bit index range
	wire       in_seg  = walign && (widx >= ADDR_SEG_BASE) &&
	                     ({1'b0, widx} < 9'(ADDR_SEG_BASE) + 9'(SEG_WORDS));
	wire       wr_seg  = do_wr && wlane && in_seg;
	wire       wr_hit  = (walign && ((widx == ADDR_CTRL_A) || (widx == ADDR_CTRL_B) ||
	                     (widx == ADDR_FRAME_RATE) || (widx == ADDR_CONTRAST))) ||
	                     in_seg;

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 10'h000;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			o_bvalid  <= 1'b0;
			o_bresp   <= RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (w_fire) begin
				w_held_q <= 1'b1;
				wdata_q  <= i_wdata;
				wstrb_q  <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (do_wr) begin
				o_bvalid <= 1'b1;
				o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Frame timing and capture
	// ----------------------------------------
	wire enabled = ctrl_a_q[BIT_DRIVE_ENABLE];
	logic frame_tick;
	slfc_frame_timer #(
		.FRAME_CYCLES (FRAME_CYCLES_P)
	) slfc_frame_timer_inst (
		.i_clk_sys     (i_clk_sys),
		.i_resetn      (i_resetn),
		.i_run         (enabled),
		.o_frame_start (frame_tick)
	);
	// Low power waveform needs two equal frames, so capture skips odd ones
	wire frame_capture = frame_tick && (!low_power_lat_q || !odd_frame_q);

	// Hardware set wins over any clear in the same cycle
	wire flag_clr  = (wr_a && wbyte[BIT_FRAME_FLAG]) || i_irq_vector_taken;
	wire flag_next = frame_capture ? 1'b1 :
	                 (flag_clr ? 1'b0 : ctrl_a_q[BIT_FRAME_FLAG]);
	wire [7:0] a_sw = wr_a ? (wbyte & CTRL_A_WMASK) : (ctrl_a_q & CTRL_A_WMASK);

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_a_q     <= RESET_VALUE;
			ctrl_b_q     <= RESET_VALUE;
			frame_rate_q <= RESET_VALUE;
			contrast_q   <= RESET_VALUE;
		end else begin
			ctrl_a_q <= a_sw | (8'(flag_next) << BIT_FRAME_FLAG);
			if (wr_b)
				ctrl_b_q <= wbyte & CTRL_B_WMASK;
			if (wr_fr)
				frame_rate_q <= wbyte & FRAME_WMASK;
			if (wr_cc)
				contrast_q <= wbyte;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			blank_lat_q     <= 1'b0;
			low_power_lat_q <= 1'b0;
			contrast_lat_q  <= 8'h00;
			odd_frame_q     <= 1'b0;
		end else if (!enabled) begin
			odd_frame_q <= 1'b0;
		end else begin
			if (frame_tick)
				odd_frame_q <= !odd_frame_q;
			if (frame_capture) begin
				blank_lat_q     <= ctrl_a_q[BIT_BLANK];
				low_power_lat_q <= ctrl_a_q[BIT_LOW_POWER];
				contrast_lat_q  <= contrast_q;
			end
		end
	end

	// ----------------------------------------
	// Segment memory and scan
	// ----------------------------------------
	// The scan reads the live memory word by word; a write shows in the stream at once,
	// as no image is latched at frame start and there is no second copy of the array.
	wire [7:0] ridx       = araddr_q[9:2];
	wire       ralign     = (araddr_q[1:0] == 2'h0);
	wire [7:0] rd_off     = ridx - ADDR_SEG_BASE;
	wire [4:0] rd_idx     = rd_off[4:0];
	wire       rd_seg_sel = rd_pend_q && ralign && (ridx >= ADDR_SEG_BASE) &&
	                        ({1'b0, ridx} < 9'(ADDR_SEG_BASE) + 9'(SEG_WORDS));

	slfc_seg_mem #(
		.WORDS (SEG_WORDS),
		.AW    (5)
	) slfc_seg_mem_inst (
		.i_clk_sys (i_clk_sys),
		.i_we      (wr_seg),
		.i_waddr   (seg_off[4:0]),
		.i_wdata   (wbyte),
		.i_raddr   (rd_seg_sel ? rd_idx : scan_q),
		.o_rdata   (seg_rdata)
	);

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			scan_q      <= 5'h00;
			scan_d1_q   <= 5'h00;
			o_seg_data  <= 8'h00;
			o_seg_index <= 5'h00;
		end else begin
			scan_q      <= (frame_capture || scan_q == 5'(SEG_WORDS - 1)) ? 5'h00 : scan_q + 5'h01;
			// Index waits out the memory's registered read so it pairs with its word
			scan_d1_q   <= scan_q;
			o_seg_index <= scan_d1_q;
			// Blanking zeroes the output stream only; memory is untouched
			o_seg_data  <= blank_lat_q ? 8'h00 : seg_rdata;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic      rd_wait_q;
	wire [7:0] rd_reg = !ralign                   ? 8'h00 :
	                    (ridx == ADDR_CTRL_A)     ? ctrl_a_q :
	                    (ridx == ADDR_CTRL_B)     ? ctrl_b_q :
	                    (ridx == ADDR_FRAME_RATE) ? frame_rate_q :
	                    (ridx == ADDR_CONTRAST)   ? contrast_q : 8'h00;
	wire       rd_hit = rd_seg_sel || (ralign && ((ridx == ADDR_CTRL_A) ||
	                    (ridx == ADDR_CTRL_B) || (ridx == ADDR_FRAME_RATE) ||
	                    (ridx == ADDR_CONTRAST)));

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			rd_pend_q <= 1'b0;
			rd_wait_q <= 1'b0;
			araddr_q  <= 10'h000;
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= RESP_OKAY;
		end else begin
			if (i_arvalid && o_arready) begin
				araddr_q  <= i_araddr;
				rd_pend_q <= 1'b1;
				o_arready <= 1'b0;
			end
			// One wait state lets the memory's registered read settle
			if (rd_pend_q && !o_rvalid) begin
				rd_wait_q <= 1'b1;
				if (rd_wait_q) begin
					o_rvalid  <= 1'b1;
					o_rdata   <= {24'h000000, rd_seg_sel ? seg_rdata : rd_reg};
					o_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
				end
			end
			if (o_rvalid && i_rready) begin
				o_rvalid  <= 1'b0;
				rd_pend_q <= 1'b0;
				rd_wait_q <= 1'b0;
				o_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Pin-facing outputs
	// ----------------------------------------
	wire [3:0] com_dec = (ctrl_b_q[5:4] == 2'h0) ? 4'h1 :
	                     (ctrl_b_q[5:4] == 2'h1) ? 4'h3 :
	                     (ctrl_b_q[5:4] == 2'h2) ? 4'h7 : 4'hF;

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_frame_irq           <= 1'b0;
			o_pins_lcd_mode       <= 1'b0;
			o_blank_active        <= 1'b0;
			o_low_power_wave      <= 1'b0;
			o_level_buffer_off    <= 1'b0;
			o_internal_supply_off <= 1'b0;
			o_drive_clock_sel     <= 1'b0;
			o_half_bias_sel       <= 1'b0;
			o_common_en           <= 4'h0;
			o_segment_pin_mask    <= 3'h0;
			o_contrast            <= 8'h00;
		end else begin
			o_frame_irq <= ctrl_a_q[BIT_FRAME_FLAG] && ctrl_a_q[BIT_IRQ_ENABLE] &&
			               i_global_irq_en;
			o_pins_lcd_mode       <= enabled;
			o_blank_active        <= blank_lat_q;
			o_low_power_wave      <= low_power_lat_q;
			o_level_buffer_off    <= ctrl_a_q[BIT_BUF_OFF];
			o_internal_supply_off <= ctrl_a_q[BIT_SUPPLY_OFF];
			o_drive_clock_sel     <= ctrl_b_q[BIT_CLOCK_SEL];
			o_half_bias_sel       <= ctrl_b_q[BIT_HALF_BIAS];
			o_common_en           <= enabled ? com_dec : 4'h0;
			o_segment_pin_mask    <= ctrl_b_q[2:0];
			o_contrast            <= contrast_lat_q;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_flag_on_frame: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		frame_capture |=> ctrl_a_q[BIT_FRAME_FLAG])
		else $error("frame flag not set at capture");
	a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		ctrl_a_q[5] == 1'b0)
		else $error("reserved bit not zero");
	a_irq_follows: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(ctrl_a_q[BIT_FRAME_FLAG] && ctrl_a_q[BIT_IRQ_ENABLE] && i_global_irq_en)
		|=> o_frame_irq)
		else $error("interrupt not raised");
	a_clear_by_one: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(wr_a && wbyte[BIT_FRAME_FLAG] && !frame_capture) |=> !ctrl_a_q[BIT_FRAME_FLAG])
		else $error("flag not cleared by write one");
	a_off_at_once: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!enabled |=> !o_pins_lcd_mode)
		else $error("pins not released");
	a_low_power_skip: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(frame_capture && low_power_lat_q) |=> !frame_capture [*2])
		else $error("capture too often in low power");
	a_blank_latched: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(wr_a && !frame_capture) |=> $stable(blank_lat_q))
		else $error("blank taken outside frame start");
	a_seg_blanked: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		blank_lat_q |=> o_seg_data == 8'h00)
		else $error("segment data not blanked");
	c_frame: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) frame_capture);
	c_irq: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_frame_irq);
	c_blank: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) blank_lat_q);
endmodule

// file: slfc_glass_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Passive glass: judges the levels it is driven with
// ----------------------------------------
module slfc_glass_model #(
	parameter logic [7:0] EXP_WORD0 = 8'h00
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_pins_lcd_mode,
	input  wire logic       i_blank_active,
	input  wire logic [3:0] i_common_en,
	input  wire logic [7:0] i_seg_data,
	input  wire logic [4:0] i_seg_index,
	output logic      [7:0] o_faults
);
	logic [7:0] faults_q = 8'h00;
	assign o_faults = faults_q;
	// A glass gives no answer, so it only counts drive faults: commons on while off, data while blanked, and a wrong word 0
	always @(posedge i_clk_sys) begin
		if (i_pins_lcd_mode !== 1'b1 && i_common_en !== 4'h0) begin
			$display("[ERR] common_en off exp 0 got %h", i_common_en);
			faults_q <= faults_q + 8'h01;
		end
		if (i_blank_active === 1'b1 && i_seg_data !== 8'h00) begin
			$display("[ERR] seg_data blanked exp 00 got %h", i_seg_data);
			faults_q <= faults_q + 8'h01;
		end
		if (i_pins_lcd_mode === 1'b1 && i_blank_active === 1'b0 && i_seg_index === 5'h00 &&
		    i_seg_data !== EXP_WORD0) begin
			$display("[ERR] seg word0 exp %h got %h", EXP_WORD0, i_seg_data);
			faults_q <= faults_q + 8'h01;
		end
	end
endmodule

// file: slfc_top_tb.sv
`timescale 1ns/100ps
module slfc_top_tb;
	import slfc_pkg::*;
	localparam int FC = 64;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [9:0]  awaddr = 10'h000;
	logic [9:0]  araddr = 10'h000;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        gie = 1'b0;
	logic        vec = 1'b0;
	logic        ack_on = 1'b0;
	logic        irq_prev = 1'b0;
	int          rises = 0;
	int          failures = 0;
	int          total_checks = 0;
	logic        aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, irq, lcd_mode, blank, lpw;
	logic        buf_off, sup_off, clk_sel, hbias;
	logic [4:0]  seg_idx;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [3:0]  com_en;
	logic [2:0]  pin_mask;
	logic [7:0]  contrast, seg_data, glass_faults;

	always #4 clk_sys = ~clk_sys;

	slfc_top #(.FRAME_CYCLES_P(FC)) slfc_top_inst (.i_clk_sys(clk_sys), .i_resetn(resetn),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(aw_rdy), .i_wdata(wdata),
		.i_wstrb(4'h1), .i_wvalid(wvalid), .o_wready(w_rdy), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(ar_rdy), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_global_irq_en(gie), .i_irq_vector_taken(vec),
		.o_frame_irq(irq), .o_pins_lcd_mode(lcd_mode), .o_blank_active(blank),
		.o_low_power_wave(lpw), .o_level_buffer_off(buf_off),
		.o_internal_supply_off(sup_off), .o_drive_clock_sel(clk_sel), .o_half_bias_sel(hbias),
		.o_common_en(com_en), .o_segment_pin_mask(pin_mask), .o_contrast(contrast),
		.o_seg_data(seg_data), .o_seg_index(seg_idx));

	slfc_glass_model #(.EXP_WORD0(8'h3C)) slfc_glass_model_inst (.i_clk_sys(clk_sys),
		.i_pins_lcd_mode(lcd_mode), .i_blank_active(blank), .i_common_en(com_en),
		.i_seg_data(seg_data), .i_seg_index(seg_idx), .o_faults(glass_faults));

	// Interrupt handler stand-in: two vector pulses per request, as irq falls only after the first has cleared the flag, plus a rise counter
	always @(posedge clk_sys) begin
		vec <= ack_on && irq && !vec;
		irq_prev <= irq;
		if (irq === 1'b1 && irq_prev !== 1'b1) rises <= rises + 1;
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		logic [1:0] r;
		n = 0;
		awaddr <= {a, 2'h0};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (awvalid && aw_rdy) awvalid <= 1'b0;
			if (wvalid && w_rdy) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		r = bresp;
		bready <= 1'b0;
		// One idle edge keeps the next call from raising bready in this step
		@(posedge clk_sys);
		chk("write done", 8'h01, {7'h0, n < 50});
		chk("write resp", {6'h0, RESP_OKAY}, {6'h0, r});
	endtask

	task automatic rd_get(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= {a, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (arvalid && ar_rdy) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
		@(posedge clk_sys);
		chk("read done", 8'h01, {7'h0, n < 50});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		logic [7:0] d;
		logic [1:0] r;
		rd_get(a, d, r);
		chk("read data", e, d);
		chk("read resp", {6'h0, er}, {6'h0, r});
	endtask

	task automatic wait_flag(output logic [7:0] d);
		logic [1:0] r;
		int n;
		d = 8'h00;
		n = 0;
		while (d[BIT_FRAME_FLAG] !== 1'b1 && n < 40) begin
			rd_get(ADDR_CTRL_A, d, r);
			n++;
		end
		chk("frame flag seen", 8'h01, {7'h0, d[BIT_FRAME_FLAG]});
	endtask

	task automatic wait_irq();
		int n;
		int r0;
		n = 0;
		r0 = rises;
		while (rises == r0 && n < 4 * FC) begin
			@(posedge clk_sys);
			n++;
		end
		chk("frame irq seen", 8'h01, {7'h0, rises != r0});
	endtask

	task automatic count_frames(input int e);
		int r0;
		r0 = rises;
		repeat (4 * FC + FC / 2) @(posedge clk_sys);
		chk("frames counted", e[7:0], 8'(rises - r0));
	endtask

	task automatic t_static();
		rd(ADDR_CTRL_A, 8'h00, RESP_OKAY);
		rd(8'h80, 8'h00, RESP_SLVERR);
		wr(ADDR_CTRL_A, 8'h26);
		rd(ADDR_CTRL_A, 8'h06, RESP_OKAY);
		chk("level_buffer_off", 8'h01, {7'h0, buf_off});
		chk("internal_supply_off", 8'h01, {7'h0, sup_off});
		wr(ADDR_CTRL_B, 8'hE4);
		rd(ADDR_CTRL_B, 8'hE4, RESP_OKAY);
		chk("drive_clock_sel", 8'h01, {7'h0, clk_sel});
		chk("half_bias_sel", 8'h01, {7'h0, hbias});
		wr(ADDR_FRAME_RATE, 8'hFF);
		rd(ADDR_FRAME_RATE, 8'h77, RESP_OKAY);
		chk("segment_pin_mask", 8'h04, {5'h0, pin_mask});
		wr(ADDR_SEG_BASE, 8'h3C);
		rd(ADDR_SEG_BASE, 8'h3C, RESP_OKAY);
	endtask

	task automatic t_enable_flag();
		logic [7:0] d;
		// Supply-off is already set, so enabling keeps the external-supply order
		wr(ADDR_CTRL_A, 8'h8E);
		chk("pins_lcd_mode", 8'h01, {7'h0, lcd_mode});
		chk("common_en", 8'h07, {4'h0, com_en});
		wait_flag(d);
		chk("flag set", 8'h9E, d);
		chk("irq masked", 8'h00, {7'h0, irq});
		wr(ADDR_CTRL_A, 8'h9E);
		rd(ADDR_CTRL_A, 8'h8E, RESP_OKAY);
		gie <= 1'b1;
		ack_on <= 1'b1;
		wait_irq();
		count_frames(4);
	endtask

	task automatic t_latch();
		wait_irq();
		wr(ADDR_CONTRAST, 8'h5A);
		wr(ADDR_CTRL_A, 8'hCF);
		chk("low_power early", 8'h00, {7'h0, lpw});
		chk("blank early", 8'h00, {7'h0, blank});
		chk("contrast early", 8'h00, contrast);
		wait_irq();
		chk("low_power latched", 8'h01, {7'h0, lpw});
		chk("blank latched", 8'h01, {7'h0, blank});
		chk("contrast latched", 8'h5A, contrast);
		count_frames(2);
		wr(ADDR_CTRL_A, 8'h8E);
		wait_irq();
		chk("blank released", 8'h00, {7'h0, blank});
		rd(ADDR_SEG_BASE, 8'h3C, RESP_OKAY);
	endtask

	task automatic t_disable();
		logic [7:0] d;
		// Handler off, so the flag stays up for polling
		ack_on <= 1'b0;
		wait_flag(d);
		// Whole value written; its flag bit is one, so this write also clears the flag
		wr(ADDR_CTRL_A, 8'h91);
		wait_flag(d);
		chk("blank before off", 8'h01, {7'h0, blank});
		// Glass discharged by blanking before the pins go back to port use
		wr(ADDR_CTRL_A, 8'h00);
		chk("pins off", 8'h00, {7'h0, lcd_mode});
		chk("commons off", 8'h00, {4'h0, com_en});
		wr(ADDR_CTRL_B, 8'h34);
		rd(ADDR_CTRL_B, 8'h34, RESP_OKAY);
	endtask

	task automatic final_report();
		$display("checks %0d failures %0d glass %0d", total_checks, failures, glass_faults);
		if (failures == 0 && glass_faults === 8'h00 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		t_static();
		t_enable_flag();
		t_latch();
		t_disable();
		final_report();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		final_report();
	end
endmodule
